//--- rtl/masm_alarm_status.sv
// Purpose: second alarm status register, both mask registers, alarm output
// Assumes: comparator levels and conversion pulses synchronous to clock
// Notes: status flags clear on read; a set in the read cycle survives
//
// Functional notes
// [RULE_01] hot crossing sets status bit 0
// [RULE_02] hot flag mode chosen by mask two bit6
// [RULE_03] board thermal alert pin sets bit 1
// [RULE_04] several sensors may share the alert pin
// [RULE_05] fan count limits set bits 2 and 3
// [RULE_06] chassis intrusion high sets bit 4
// [RULE_07] overtemp limit crossing sets bit 5, comparator
// [RULE_08] overtemp flag mode chosen by mask two bit7
// [RULE_09] status two read only, reserved, resets zero
// [RULE_10] mask one blocks status from alarm
// [RULE_11] mask one read/write, voltage and external flags
// [RULE_12] mask two read/write, bits 0-4 masks; the code masks bits 0-5
// [RULE_13] default mode re-sets flag each conversion above hysteresis
// [RULE_14] one-time mode: once until below hysteresis
// [RULE_15] alarm driven only when output enable set
// [RULE_16] external alarm flag zero means low detected
// [RULE_17] reserved status bits read zero always
// [RULE_18] alarm is OR of unmasked flags
module masm_alarm_status (
  input wire logic clock, // 50 MHz system clock
  input wire logic rstn, // async reset, active low
  input wire logic [7:0] reg_addr, // register pointer
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_rd, // read strobe, one cycle
  output logic [7:0] reg_rdata, // read data, valid cycle after reg_rd
  input wire logic conv_done, // conversion complete pulse
  input wire logic [1:0] temp_above_limit, // above hot limit: 0 hot, 1 overtemp
  input wire logic [1:0] temp_below_hyst, // below hysteresis: 0 hot, 1 overtemp
  input wire logic board_thermal_alert_n, // shared thermal alert pin, low active
  input wire logic first_tach_monitor, // first fan count limit exceeded
  input wire logic second_tach_monitor, // second fan count limit exceeded
  input wire logic chassis_intrusion, // chassis intrusion latch output
  input wire logic [6:0] voltage_flags, // voltage_flag_zero..six from status one
  input wire logic ext_alarm_flag, // status one bit 7, zero when input low
  input wire logic alarm_out_en, // configuration alarm output enable
  output logic alarm_o, // alarm pin output value, always low
  output logic alarm_oe // alarm pin drive enable, high pulls pin low
);

  typedef struct packed {
    logic [masm_pkg::STATUS_BITS-1:0] status;
    logic [7:0] mask_one;
    logic [7:0] mask_two;
    logic [masm_pkg::TEMP_CHANNELS-1:0] hot;
    logic [7:0] rdata;
    logic alarm;
  } masm_state_type;

  masm_state_type state_q;
  masm_state_type state_d;

  logic status_read;
  logic [masm_pkg::STATUS_BITS-1:0] set_ev;
  logic [masm_pkg::TEMP_CHANNELS-1:0] temp_set;
  logic [masm_pkg::TEMP_CHANNELS-1:0] hot_next;
  logic [masm_pkg::TEMP_CHANNELS-1:0] one_time;
  logic [7:0] status_view;
  logic [7:0] group_one;

  // temperature flag modes; one-time trades repeat alarms for a quiet host
  always_comb begin
    one_time = {state_q.mask_two[masm_pkg::BIT_OVERTEMP_MODE],
                state_q.mask_two[masm_pkg::BIT_HOT_MODE]}; // see [RULE_02] see [RULE_08]
    for (int i = 0; i < masm_pkg::TEMP_CHANNELS; i++) begin
      hot_next[i] = state_q.hot[i];
      temp_set[i] = 1'b0;
      if (conv_done) begin
        // comparator view: above limit enters, below hysteresis leaves
        if (temp_above_limit[i]) begin
          hot_next[i] = 1'b1; // see [RULE_07]
        end else if (temp_below_hyst[i]) begin
          hot_next[i] = 1'b0; // see [RULE_14]
        end
        if (one_time[i]) begin
          temp_set[i] = hot_next[i] & ~state_q.hot[i]; // see [RULE_14]
        end else begin
          temp_set[i] = hot_next[i]; // see [RULE_13]
        end
      end
    end
  end

  // event sources of status two; alert pin may be a wired-or of sensors
  always_comb begin
    set_ev = '0;
    set_ev[masm_pkg::BIT_HOT] = temp_set[0]; // see [RULE_01]
    set_ev[masm_pkg::BIT_BOARD_ALERT] = ~board_thermal_alert_n; // see [RULE_03] see [RULE_04]
    set_ev[masm_pkg::BIT_FIRST_TACH] = first_tach_monitor; // see [RULE_05]
    set_ev[masm_pkg::BIT_SECOND_TACH] = second_tach_monitor; // see [RULE_05]
    set_ev[masm_pkg::BIT_CHASSIS] = chassis_intrusion; // see [RULE_06]
    set_ev[masm_pkg::BIT_OVERTEMP] = temp_set[1]; // see [RULE_07]
  end

  assign status_read = reg_rd && (reg_addr == masm_pkg::ADDR_STATUS_TWO);
  assign status_view = {masm_pkg::RESERVED_READ, state_q.status}; // see [RULE_17]
  // external flag is active when it reads zero
  assign group_one = {~ext_alarm_flag, voltage_flags}; // see [RULE_16]

  // next state: registers, read mux, alarm request
  always_comb begin
    state_d = state_q;
    state_d.hot = hot_next;
    // set wins over the clear-on-read so no event is lost
    if (status_read) begin
      state_d.status = set_ev; // see [RULE_13]
    end else begin
      state_d.status = state_q.status | set_ev;
    end
    if (reg_wr) begin
      unique case (reg_addr)
        masm_pkg::ADDR_MASK_ONE: state_d.mask_one = reg_wdata; // see [RULE_11]
        masm_pkg::ADDR_MASK_TWO: state_d.mask_two = reg_wdata; // see [RULE_12]
        default: ; // status two ignores writes, see [RULE_09]
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        masm_pkg::ADDR_STATUS_TWO: state_d.rdata = status_view;
        masm_pkg::ADDR_MASK_ONE: state_d.rdata = state_q.mask_one;
        masm_pkg::ADDR_MASK_TWO: state_d.rdata = state_q.mask_two;
        default: state_d.rdata = 8'h00;
      endcase
    end
    // unmasked flags only; mode bits of mask two are not masks
    state_d.alarm = alarm_out_en &&
      ((|(state_q.status & ~state_q.mask_two[masm_pkg::STATUS_BITS-1:0])) ||
       (|(group_one & ~state_q.mask_one))); // see [RULE_10] see [RULE_15] see [RULE_18]
  end

  // state register
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q.status <= masm_pkg::RST_STATUS; // see [RULE_09]
      state_q.mask_one <= masm_pkg::RST_MASK_ONE;
      state_q.mask_two <= masm_pkg::RST_MASK_TWO;
      state_q.hot <= '0;
      state_q.rdata <= 8'h00;
      state_q.alarm <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  // read data and drive enable straight from flops; open-drain pin only pulls low
  assign reg_rdata = state_q.rdata;
  assign alarm_oe = state_q.alarm;
  assign alarm_o = 1'b0;

  // checks: one each for twelve device-side rules; level inputs re-set flags every cycle,
  // so most checks look one edge after the cause
  a_status_reset: assert property (@(posedge clock) // see [RULE_09]
    $rose(rstn) |-> $past(state_q.status) == masm_pkg::RST_STATUS)
    else $error("status not zero after reset");

  a_reserved_zero: assert property (@(posedge clock) disable iff (!rstn) // see [RULE_17]
    $past(reg_rd) && $past(reg_addr) == masm_pkg::ADDR_STATUS_TWO |-> reg_rdata[7:6] == 2'h0)
    else $error("reserved status bits not zero");

  a_chassis_sets: assert property (@(posedge clock) disable iff (!rstn) // see [RULE_06]
    chassis_intrusion |=> state_q.status[masm_pkg::BIT_CHASSIS])
    else $error("chassis intrusion did not set flag");

  a_alert_sets: assert property (@(posedge clock) disable iff (!rstn) // see [RULE_03]
    !board_thermal_alert_n |=> state_q.status[masm_pkg::BIT_BOARD_ALERT])
    else $error("board alert did not set flag");

  a_fan_sets: assert property (@(posedge clock) disable iff (!rstn) // see [RULE_05]
    (first_tach_monitor |=> state_q.status[masm_pkg::BIT_FIRST_TACH]) and
    (second_tach_monitor |=> state_q.status[masm_pkg::BIT_SECOND_TACH]))
    else $error("fan limits did not set flags");

  a_alarm_gated: assert property (@(posedge clock) disable iff (!rstn) // see [RULE_15]
    !alarm_out_en |=> !alarm_oe)
    else $error("alarm driven while disabled");

  a_mask_blocks: assert property (@(posedge clock) disable iff (!rstn) // see [RULE_10]
    alarm_out_en && (&state_q.mask_one) &&
      (&state_q.mask_two[masm_pkg::STATUS_BITS-1:0]) |=> !alarm_oe)
    else $error("fully masked alarm driven");

  a_alarm_flag: assert property (@(posedge clock) disable iff (!rstn) // see [RULE_18]
    alarm_out_en && state_q.status[masm_pkg::BIT_CHASSIS] &&
      !state_q.mask_two[masm_pkg::BIT_CHASSIS] |=> alarm_oe)
    else $error("unmasked flag did not drive alarm");

  a_ext_flag: assert property (@(posedge clock) disable iff (!rstn) // see [RULE_16]
    alarm_out_en && !ext_alarm_flag && !state_q.mask_one[masm_pkg::VOLT_FLAGS] |=> alarm_oe)
    else $error("external flag low did not drive alarm");

  a_one_time: assert property (@(posedge clock) disable iff (!rstn) // see [RULE_14]
    conv_done && one_time[0] && state_q.hot[0] && !status_read |=>
      state_q.status[masm_pkg::BIT_HOT] == $past(state_q.status[masm_pkg::BIT_HOT]))
    else $error("one-time flag raised twice");

  a_default_mode: assert property (@(posedge clock) disable iff (!rstn) // see [RULE_13]
    conv_done && !one_time[0] && temp_above_limit[0] |=> state_q.status[masm_pkg::BIT_HOT])
    else $error("default mode flag not set");

  a_mask_write: assert property (@(posedge clock) disable iff (!rstn) // see [RULE_12]
    reg_wr && reg_addr == masm_pkg::ADDR_MASK_TWO |=> state_q.mask_two == $past(reg_wdata))
    else $error("mask two write lost");


  // covers: clear on read, alarm rising, overtemp flag, mode machine, full masking
  c_read_clear: cover property (@(posedge clock) disable iff (!rstn)
    state_q.status[masm_pkg::BIT_HOT] ##1 status_read ##1 !state_q.status[masm_pkg::BIT_HOT]);
  c_alarm_on: cover property (@(posedge clock) disable iff (!rstn) $rose(alarm_oe));
  c_overtemp: cover property (@(posedge clock) disable iff (!rstn)
    $rose(state_q.status[masm_pkg::BIT_OVERTEMP]));
  c_one_time: cover property (@(posedge clock) disable iff (!rstn)
    conv_done && one_time[0] && state_q.hot[0] && temp_above_limit[0]);
  c_all_masked: cover property (@(posedge clock) disable iff (!rstn)
    alarm_out_en && (|state_q.status) && (&state_q.mask_one) &&
    (&state_q.mask_two[masm_pkg::STATUS_BITS-1:0]));

endmodule // masm_alarm_status

//--- rtl/masm_pkg.sv
// Purpose: shared constants for the alarm status and mask block
// Assumes: 8-bit register pointer, one 50 MHz clock
// Notes: offsets are the register pointer values
package masm_pkg;
  // register pointer values
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h02;
  localparam logic [7:0] ADDR_MASK_ONE = 8'h03;
  localparam logic [7:0] ADDR_MASK_TWO = 8'h44;

  // reset values
  localparam logic [7:0] RST_MASK_ONE = 8'h00;
  localparam logic [7:0] RST_MASK_TWO = 8'h00;
  localparam logic [5:0] RST_STATUS = 6'h00;

  // status two field positions
  localparam int BIT_HOT = 0;
  localparam int BIT_BOARD_ALERT = 1;
  localparam int BIT_FIRST_TACH = 2;
  localparam int BIT_SECOND_TACH = 3;
  localparam int BIT_CHASSIS = 4;
  localparam int BIT_OVERTEMP = 5;
  localparam int STATUS_BITS = 6;

  // mask two mode select positions
  localparam int BIT_HOT_MODE = 6;
  localparam int BIT_OVERTEMP_MODE = 7;

  // mask one: bits 0..6 voltage flags, bit 7 external alarm input flag
  localparam int VOLT_FLAGS = 7;

  // temperature channels using the mode machine: 0 hot, 1 overtemp
  localparam int TEMP_CHANNELS = 2;

  // reserved bits of status two read as zero
  localparam logic [1:0] RESERVED_READ = 2'h0;
endpackage : masm_pkg

//--- testbench/masm_board_model.sv
// Purpose: board and host side of the alarm wire and shared alert line
// Assumes: open-drain alarm pin with pull-up, open-drain sensors
// Notes: host only ever sees the pulled-up wire level
module masm_board_model (
  input wire logic alarm_o, // pin value from the block
  input wire logic alarm_oe, // pin drive enable
  input wire logic [1:0] sensor_alert_n, // two sensor thermostat outputs
  output logic alarm_n, // wire level seen by host
  output logic board_thermal_alert_n // shared alert line
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-up wins when nobody drives, never a stale value
  assign alarm_n = alarm_oe ? alarm_o : 1'b1;
  // wired-and: any sensor pulling low alerts the board
  assign board_thermal_alert_n = &sensor_alert_n;
endmodule // masm_board_model

//--- testbench/monitor_alarm_status_mask_test.sv
// Purpose: self-checking bench for the alarm status and mask block
// Assumes: strobe register port, reads answered one cycle later
// Notes: reads queue their expected value, a watcher compares
module monitor_alarm_status_mask_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rstn, reg_wr, reg_rd, conv_done, ext_alarm_flag, alarm_out_en;
  logic rd_seen = 1'b0; // a read strobe was taken at the last edge
  logic [7:0] reg_addr, reg_wdata, reg_rdata, m;
  logic [1:0] temp_above_limit, temp_below_hyst, sensor_alert_n;
  logic [2:0] lvl; // tach one, tach two, chassis
  logic [6:0] voltage_flags;
  logic alarm_o, alarm_oe, alarm_n, board_thermal_alert_n;
  logic [7:0] exp_q[$];
  int n_fail, check_count;

  masm_alarm_status i_masm_alarm_status (.clock(clock), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_done(conv_done), .temp_above_limit(temp_above_limit),
    .temp_below_hyst(temp_below_hyst), .board_thermal_alert_n(board_thermal_alert_n),
    .first_tach_monitor(lvl[0]), .second_tach_monitor(lvl[1]),
    .chassis_intrusion(lvl[2]), .voltage_flags(voltage_flags),
    .ext_alarm_flag(ext_alarm_flag), .alarm_out_en(alarm_out_en),
    .alarm_o(alarm_o), .alarm_oe(alarm_oe));
  masm_board_model i_masm_board_model (.alarm_o(alarm_o), .alarm_oe(alarm_oe),
    .sensor_alert_n(sensor_alert_n), .alarm_n(alarm_n),
    .board_thermal_alert_n(board_thermal_alert_n));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock);
    reg_rd <= 1'b0;
  endtask

  task automatic conv(input logic [1:0] above, input logic [1:0] below);
    @(posedge clock);
    temp_above_limit <= above;
    temp_below_hyst <= below;
    conv_done <= 1'b1;
    @(posedge clock);
    conv_done <= 1'b0;
  endtask

  // alarm pin trails its cause by two cycles, one spare allowed
  task automatic alarm_is(input logic lv);
    repeat (3) @(posedge clock);
    check({7'h0, alarm_n}, {7'h0, lv});
  endtask

  // read data stands from the edge after the strobe
  always @(posedge clock) begin
    if (rd_seen === 1'b1) check(reg_rdata, exp_q.pop_front());
    rd_seen = reg_rd;
  end

  // hang guard, the run needs about 140 cycles
  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    stop_test();
  end

  initial begin
    {rstn, reg_wr, reg_rd, conv_done, alarm_out_en} = '0;
    {reg_addr, reg_wdata, temp_above_limit, temp_below_hyst, lvl, voltage_flags} = '0;
    ext_alarm_flag = 1'b1;
    sensor_alert_n = 2'h3;
    n_fail = 0;
    check_count = 0;
    void'($urandom(32'hdc51));
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h00);
    rd(8'h44, 8'h00);
    m = 8'($urandom);
    wr(8'h03, m);
    rd(8'h03, m);
    m = 8'($urandom);
    wr(8'h44, m);
    rd(8'h44, m);
    wr(8'h02, 8'hff);
    rd(8'h02, 8'h00);
    rd(8'h10, 8'h00);
    wr(8'h44, 8'h00);
    // one-cycle level events, then clear on read
    for (int b = 1; b < 5; b++) begin
      @(posedge clock);
      if (b == 1) sensor_alert_n <= 2'h1;
      else lvl <= 3'(1 << (b - 2));
      @(posedge clock);
      sensor_alert_n <= 2'h3;
      lvl <= '0;
      rd(8'h02, 8'(1 << b));
      rd(8'h02, 8'h00);
    end
    // other channel held below hysteresis so it stays quiet
    for (int c = 0; c < 2; c++) begin
      wr(8'h44, 8'h00);
      conv(2'(1 << c), ~2'(1 << c));
      rd(8'h02, c ? 8'h20 : 8'h01);
      conv(2'(1 << c), ~2'(1 << c));
      rd(8'h02, c ? 8'h20 : 8'h01);
      wr(8'h44, c ? 8'h80 : 8'h40);
      conv(2'h0, 2'h3);
      conv(2'(1 << c), ~2'(1 << c));
      rd(8'h02, c ? 8'h20 : 8'h01);
      conv(2'(1 << c), ~2'(1 << c));
      rd(8'h02, 8'h00);
    end
    alarm_out_en <= 1'b1;
    lvl <= 3'h4;
    alarm_is(1'b0);
    wr(8'h44, 8'h10);
    alarm_is(1'b1);
    alarm_out_en <= 1'b0;
    wr(8'h44, 8'h00);
    alarm_is(1'b1);
    lvl <= '0;
    rd(8'h02, 8'h10);
    // mask one still holds the random value of the register test
    wr(8'h03, 8'h00);
    alarm_out_en <= 1'b1;
    ext_alarm_flag <= 1'b0;
    alarm_is(1'b0);
    wr(8'h03, 8'h80);
    alarm_is(1'b1);
    ext_alarm_flag <= 1'b1;
    voltage_flags <= 7'($urandom) | 7'h01;
    alarm_is(1'b0);
    wr(8'h03, 8'h7f);
    alarm_is(1'b1);
    // external, voltage, fan and chassis flags raised, every mask bit set: the pin must stay quiet
    ext_alarm_flag <= 1'b0;
    lvl <= 3'h7;
    wr(8'h03, 8'hff);
    wr(8'h44, 8'h3f);
    alarm_is(1'b1);
    lvl <= '0;
    rd(8'h02, 8'h1c);
    alarm_is(1'b1);
    stop_test();
  end
endmodule // monitor_alarm_status_mask_test
